// [pkg/pbec_pkg.sv]
// Summary of operation
// - transmit counter counts each sent bit
// - receive counter counts each received bit
// - error counter counts each bit error
// - 48-bit counts read as three 16-bit words
// - without clear-on-read, reads leave counters alone
// - without clear-on-read, clear on request edge, soft reset or rstn only
// - with clear-on-read, reading clears the word
// - transmit low read snapshots upper transmit words
// - receive low read snapshots upper receive words
// - error low read snapshots upper error words
// - elapsed timer advances once per two seconds
// - elapsed timer valid only in rate mode
// - error low read snapshots elapsed timer too
// - elapsed timer cleared by request edge
// - clear request bit returns to zero itself
// - immediate enable counts errors before lock
// - rate select: 0 legacy, 1 rate; resets 1
package pbec_pkg;

   localparam int unsigned PBEC_CLK_HZ       = 40_000_000;
   localparam int unsigned PBEC_TIMER_PERIOD_S = 2;
   localparam int unsigned PBEC_TICK_CYCLES  =
      PBEC_TIMER_PERIOD_S * PBEC_CLK_HZ;
   localparam int unsigned PBEC_PRESC_W      = 27;
   localparam int unsigned PBEC_AW           = 18;

   // register indices; byte address is four times the index
   localparam logic [15:0] PBEC_IDX_CTRL     = 16'hf040;
   localparam logic [15:0] PBEC_IDX_TX_LOW   = 16'hf041;
   localparam logic [15:0] PBEC_IDX_TX_MID   = 16'hf042;
   localparam logic [15:0] PBEC_IDX_TX_HIGH  = 16'hf043;
   localparam logic [15:0] PBEC_IDX_RX_LOW   = 16'hf044;
   localparam logic [15:0] PBEC_IDX_RX_MID   = 16'hf045;
   localparam logic [15:0] PBEC_IDX_RX_HIGH  = 16'hf046;
   localparam logic [15:0] PBEC_IDX_ERR_LOW  = 16'hf047;
   localparam logic [15:0] PBEC_IDX_ERR_MID  = 16'hf048;
   localparam logic [15:0] PBEC_IDX_ERR_HIGH = 16'hf049;
   localparam logic [15:0] PBEC_IDX_TIMER    = 16'hf04a;
   localparam logic [15:0] PBEC_IDX_TX_ALIAS  = 16'hf031;
   localparam logic [15:0] PBEC_IDX_RX_ALIAS  = 16'hf034;
   localparam logic [15:0] PBEC_IDX_ERR_ALIAS = 16'hf03a;
   localparam logic [15:0] PBEC_IDX_IRQ_STS  = 16'hf050;
   localparam logic [15:0] PBEC_IDX_IRQ_MSK  = 16'hf051;

   // control word field positions
   localparam int unsigned PBEC_B_RATE   = 14;
   localparam int unsigned PBEC_B_COR    = 13;
   localparam int unsigned PBEC_B_LOCK   = 8;
   localparam int unsigned PBEC_B_IMM    = 7;
   localparam int unsigned PBEC_B_CLR    = 6;
   localparam int unsigned PBEC_B_TX_EN  = 5;
   localparam int unsigned PBEC_B_RX_EN  = 4;

   localparam logic        PBEC_RST_RATE = 1'h1;
   localparam logic [47:0] PBEC_RST_CNT  = 48'h0000_0000_0000;
   localparam logic [31:0] PBEC_RST_SNAP = 32'h0000_0000;
   localparam logic [15:0] PBEC_RST_TMR  = 16'h0000;

   // interrupt status bits
   localparam int unsigned PBEC_IRQ_W    = 3;
   localparam int unsigned PBEC_I_ERR    = 0;
   localparam int unsigned PBEC_I_TICK   = 1;
   localparam int unsigned PBEC_I_CLR    = 2;

   typedef struct packed {
      logic                psel;
      logic                penable;
      logic                pwrite;
      logic [PBEC_AW-1:0]  paddr;
      logic [31:0]         pwdata;
   } pbec_apb_req_t;

   typedef struct packed {
      logic tx_bit;
      logic rx_bit;
      logic rx_err;
      logic pattern_locked;
   } pbec_lane_t;

   typedef struct packed {
      logic       rate_accumulation_select;
      logic       clear_on_read;
      logic       immediate_count;
      logic       counter_clear_request;
      logic       tx_enable;
      logic       rx_enable;
      logic [3:0] pattern_select;
   } pbec_ctrl_t;

endpackage

// [rtl/pbec_top.sv]
`timescale 1ns/1ps
module pbec_top
   import pbec_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = PBEC_TICK_CYCLES
) (
   input  wire logic          mclk,
   input  wire logic          rstn,
   input  wire logic          soft_reset,
   input  wire pbec_apb_req_t apb_req,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire pbec_lane_t    lane,
   output logic               tx_enable,
   output logic               rx_enable,
   output logic [3:0]         pattern_select,
   output logic               irq
);

   typedef struct packed {
      pbec_ctrl_t              ctl;
      logic [47:0]             tx_cnt;
      logic [47:0]             rx_cnt;
      logic [47:0]             err_cnt;
      logic [31:0]             tx_snap;
      logic [31:0]             rx_snap;
      logic [31:0]             err_snap;
      logic [15:0]             tmr;
      logic [15:0]             tmr_snap;
      logic [PBEC_PRESC_W-1:0] presc;
      logic [PBEC_IRQ_W-1:0]   sts;
      logic [PBEC_IRQ_W-1:0]   msk;
      logic                    irq;
      logic [31:0]             prdata;
      logic                    pready;
      logic                    pslverr;
   } pbec_state_t;

   localparam logic [PBEC_PRESC_W-1:0] TICK_LAST =
      PBEC_PRESC_W'(TICK_CYCLES - 1);

   pbec_state_t             r;
   pbec_state_t             n;
   logic [15:0]             idx;
   logic                    rd;
   logic                    wr;
   logic                    hit;
   logic [15:0]             rdat;
   logic                    rd_txl;
   logic                    rd_rxl;
   logic                    rd_errl;
   logic                    cor;
   logic                    tx_inc;
   logic                    rx_inc;
   logic                    err_inc;
   logic                    tmr_run;
   logic                    tick;
   logic                    clr_now;

   always_comb begin
      n       = r;
      idx     = apb_req.paddr[PBEC_AW-1:2];
      rd      = apb_req.psel & apb_req.penable & ~apb_req.pwrite & ~r.pready;
      wr      = apb_req.psel & apb_req.penable & apb_req.pwrite & ~r.pready;
      cor     = r.ctl.clear_on_read;
      clr_now = r.ctl.counter_clear_request;
      hit     = (apb_req.paddr[1:0] == 2'h0);
      rdat    = 16'h0000;
      case (idx)
         PBEC_IDX_CTRL: begin
            rdat = 16'h0000;
            rdat[PBEC_B_RATE]  = r.ctl.rate_accumulation_select;
            rdat[PBEC_B_COR]   = r.ctl.clear_on_read;
            rdat[PBEC_B_LOCK]  = lane.pattern_locked;
            rdat[PBEC_B_IMM]   = r.ctl.immediate_count;
            rdat[PBEC_B_CLR]   = r.ctl.counter_clear_request;
            rdat[PBEC_B_TX_EN] = r.ctl.tx_enable;
            rdat[PBEC_B_RX_EN] = r.ctl.rx_enable;
            rdat[3:0]          = r.ctl.pattern_select;
         end
         PBEC_IDX_TX_LOW, PBEC_IDX_TX_ALIAS: rdat = r.tx_cnt[15:0];
         PBEC_IDX_TX_MID:    rdat = r.tx_snap[15:0];
         PBEC_IDX_TX_HIGH:   rdat = r.tx_snap[31:16];
         PBEC_IDX_RX_LOW, PBEC_IDX_RX_ALIAS: rdat = r.rx_cnt[15:0];
         PBEC_IDX_RX_MID:    rdat = r.rx_snap[15:0];
         PBEC_IDX_RX_HIGH:   rdat = r.rx_snap[31:16];
         PBEC_IDX_ERR_LOW, PBEC_IDX_ERR_ALIAS: rdat = r.err_cnt[15:0];
         PBEC_IDX_ERR_MID:   rdat = r.err_snap[15:0];
         PBEC_IDX_ERR_HIGH:  rdat = r.err_snap[31:16];
         PBEC_IDX_TIMER:     rdat = r.tmr_snap;
         PBEC_IDX_IRQ_STS:   rdat = {13'h0000, r.sts};
         PBEC_IDX_IRQ_MSK:   rdat = {13'h0000, r.msk};
         default:            hit  = 1'b0;
      endcase
      rd_txl  = rd & hit & ((idx == PBEC_IDX_TX_LOW) |
                            (idx == PBEC_IDX_TX_ALIAS));
      rd_rxl  = rd & hit & ((idx == PBEC_IDX_RX_LOW) |
                            (idx == PBEC_IDX_RX_ALIAS));
      rd_errl = rd & hit & ((idx == PBEC_IDX_ERR_LOW) |
                            (idx == PBEC_IDX_ERR_ALIAS));

      tx_inc  = r.ctl.tx_enable & lane.tx_bit;
      rx_inc  = r.ctl.rx_enable & lane.rx_bit;
      err_inc = r.ctl.rx_enable & lane.rx_err &
                (r.ctl.immediate_count | lane.pattern_locked);

      // low-word read freezes the upper words for the rest of the read
      if (rd_txl) n.tx_snap = r.tx_cnt[47:16];
      if (rd_rxl) n.rx_snap = r.rx_cnt[47:16];
      if (rd_errl) begin
         n.err_snap = r.err_cnt[47:16];
         n.tmr_snap = r.tmr;
      end

      // clear on read: live count at the low read, snapshot per word
      n.tx_cnt  = ((rd_txl & cor) ? PBEC_RST_CNT : r.tx_cnt)
                  + {47'h0000_0000_0000, tx_inc};
      n.rx_cnt  = ((rd_rxl & cor) ? PBEC_RST_CNT : r.rx_cnt)
                  + {47'h0000_0000_0000, rx_inc};
      n.err_cnt = ((rd_errl & cor) ? PBEC_RST_CNT : r.err_cnt)
                  + {47'h0000_0000_0000, err_inc};
      if (rd & hit & cor) begin
         if (idx == PBEC_IDX_TX_MID)   n.tx_snap[15:0]   = 16'h0000;
         if (idx == PBEC_IDX_TX_HIGH)  n.tx_snap[31:16]  = 16'h0000;
         if (idx == PBEC_IDX_RX_MID)   n.rx_snap[15:0]   = 16'h0000;
         if (idx == PBEC_IDX_RX_HIGH)  n.rx_snap[31:16]  = 16'h0000;
         if (idx == PBEC_IDX_ERR_MID)  n.err_snap[15:0]  = 16'h0000;
         if (idx == PBEC_IDX_ERR_HIGH) n.err_snap[31:16] = 16'h0000;
         if (idx == PBEC_IDX_TIMER)    n.tmr_snap        = PBEC_RST_TMR;
      end

      // elapsed time runs only while rate mode measures received data
      tmr_run = r.ctl.rate_accumulation_select & r.ctl.rx_enable;
      tick    = tmr_run & (r.presc == TICK_LAST);
      if (!tmr_run || tick) n.presc = '0;
      else n.presc = r.presc + PBEC_PRESC_W'(1);
      n.tmr = ((rd_errl & cor) ? PBEC_RST_TMR : r.tmr)
              + {15'h0000, tick};

      // pending clear request wipes all counts, snapshots and the timer, then drops by itself
      if (clr_now) begin
         n.tx_cnt   = PBEC_RST_CNT;
         n.rx_cnt   = PBEC_RST_CNT;
         n.err_cnt  = PBEC_RST_CNT;
         n.tx_snap  = PBEC_RST_SNAP;
         n.rx_snap  = PBEC_RST_SNAP;
         n.err_snap = PBEC_RST_SNAP;
         n.tmr      = PBEC_RST_TMR;
         n.tmr_snap = PBEC_RST_TMR;
         n.presc    = '0;
         n.ctl.counter_clear_request = 1'b0;
      end

      if (wr & hit & (idx == PBEC_IDX_CTRL)) begin
         n.ctl.rate_accumulation_select =
            apb_req.pwdata[PBEC_B_RATE];
         n.ctl.clear_on_read   = apb_req.pwdata[PBEC_B_COR];
         n.ctl.immediate_count = apb_req.pwdata[PBEC_B_IMM];
         n.ctl.tx_enable       = apb_req.pwdata[PBEC_B_TX_EN];
         n.ctl.rx_enable       = apb_req.pwdata[PBEC_B_RX_EN];
         n.ctl.pattern_select  = apb_req.pwdata[3:0];
         // only a 0-to-1 change of the request starts a clear
         if (apb_req.pwdata[PBEC_B_CLR] & ~r.ctl.counter_clear_request)
            n.ctl.counter_clear_request = 1'b1;
      end
      if (wr & hit & (idx == PBEC_IDX_IRQ_MSK))
         n.msk = apb_req.pwdata[PBEC_IRQ_W-1:0];

      // status clears on read, a same-cycle event still lands
      if (rd & hit & (idx == PBEC_IDX_IRQ_STS)) n.sts = '0;
      if (err_inc) n.sts[PBEC_I_ERR]  = 1'b1;
      if (tick)    n.sts[PBEC_I_TICK] = 1'b1;
      if (clr_now) n.sts[PBEC_I_CLR]  = 1'b1;

      if (soft_reset) begin
         n.tx_cnt   = PBEC_RST_CNT;
         n.rx_cnt   = PBEC_RST_CNT;
         n.err_cnt  = PBEC_RST_CNT;
         n.tx_snap  = PBEC_RST_SNAP;
         n.rx_snap  = PBEC_RST_SNAP;
         n.err_snap = PBEC_RST_SNAP;
         n.tmr      = PBEC_RST_TMR;
         n.tmr_snap = PBEC_RST_TMR;
         n.presc    = '0;
         n.ctl      = '{rate_accumulation_select: PBEC_RST_RATE,
                        clear_on_read: r.ctl.clear_on_read,
                        default: '0};
      end
      n.irq = |(n.sts & n.msk);

      n.pready  = apb_req.psel & apb_req.penable & ~r.pready;
      n.pslverr = (rd | wr) & ~hit;
      if (rd) n.prdata = hit ? {16'h0000, rdat} : 32'h0000_0000;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         r     <= '0;
         r.ctl.rate_accumulation_select <= PBEC_RST_RATE;
      end else begin
         r <= n;
      end
   end

   assign prdata         = r.prdata;
   assign pready         = r.pready;
   assign pslverr        = r.pslverr;
   assign irq            = r.irq;
   assign tx_enable      = r.ctl.tx_enable;
   assign rx_enable      = r.ctl.rx_enable;
   assign pattern_select = r.ctl.pattern_select;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_clr_write;
      wr && hit && idx == PBEC_IDX_CTRL && apb_req.pwdata[PBEC_B_CLR]
      && !r.ctl.counter_clear_request && !soft_reset;
   endsequence
   sequence s_clr_done;
      r.ctl.counter_clear_request ##1
      (!r.ctl.counter_clear_request && r.tx_cnt <= 48'h0000_0000_0001);
   endsequence

   AST_CLEAR_SEQ: assert property (
      s_clr_write |=> s_clr_done)
      else $error("clear request did not clear and self clear");
   AST_TX_COUNT: assert property (
      (tx_inc && !clr_now && !soft_reset && !(rd_txl && cor))
      |=> r.tx_cnt == $past(r.tx_cnt) + 48'h0000_0000_0001)
      else $error("transmit counter did not advance by one");
   AST_RX_HOLD: assert property (
      (!r.ctl.rx_enable && !rd_rxl && !clr_now && !soft_reset)
      |=> r.rx_cnt == $past(r.rx_cnt))
      else $error("receive counter moved while checking disabled");
   AST_ERR_GATE: assert property (
      (lane.rx_err && r.ctl.rx_enable && !r.ctl.immediate_count
       && !lane.pattern_locked && !rd_errl && !clr_now && !soft_reset)
      |=> r.err_cnt == $past(r.err_cnt))
      else $error("error counted before lock");
   AST_NO_COR: assert property (
      (rd_txl && !cor && !tx_inc && !clr_now && !soft_reset)
      |=> r.tx_cnt == $past(r.tx_cnt))
      else $error("read changed counter without clear on read");
   AST_COR: assert property (
      (rd_errl && cor) |=> r.err_cnt <= 48'h0000_0000_0001)
      else $error("clear on read did not clear error count");
   AST_SNAP: assert property (
      (rd_txl && !clr_now && !soft_reset)
      |=> r.tx_snap == $past(r.tx_cnt[47:16]))
      else $error("upper transmit words not snapshot on low read");
   AST_RX_SNAP: assert property (
      (rd_rxl && !clr_now && !soft_reset)
      |=> r.rx_snap == $past(r.rx_cnt[47:16]))
      else $error("upper receive words not snapshot on low read");
   AST_TMR_SNAP: assert property (
      (rd_errl && !clr_now && !soft_reset)
      |=> r.tmr_snap == $past(r.tmr) && r.err_snap == $past(r.err_cnt[47:16]))
      else $error("timer and error snapshot disagree");
   AST_TMR_TICK: assert property (
      (tick && !clr_now && !soft_reset && !(rd_errl && cor))
      |=> r.tmr == $past(r.tmr) + 16'h0001 && r.presc == '0)
      else $error("elapsed timer missed its tick");
   AST_TMR_MODE: assert property (
      !r.ctl.rate_accumulation_select |=> !tick[*2])
      else $error("elapsed timer ran outside rate mode");
   AST_SOFT: assert property (
      soft_reset |=> r.tx_cnt == '0 && r.rx_cnt == '0 && r.err_cnt == '0
                     && r.tmr == '0)
      else $error("soft reset left counts");
   AST_IRQ: assert property (
      $rose(r.sts[PBEC_I_ERR]) && r.msk[PBEC_I_ERR] |-> irq)
      else $error("masked-in status did not raise interrupt");

endmodule // pbec_top

// [testbench/test_prbs_bit_error_counters.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   begin \
      compares++; \
      if ((got) !== (ex)) begin \
         fail_count++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
      end \
   end

module test_prbs_bit_error_counters
   import pbec_pkg::*;
;
   localparam int unsigned TICKS = 8;

   logic          mclk;
   logic          rstn;
   logic          soft_reset;
   pbec_apb_req_t apb_req;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   pbec_lane_t    lane;
   logic          tx_enable;
   logic          rx_enable;
   logic [3:0]    pattern_select;
   logic          irq;
   int            fail_count;
   int            compares;
   logic [15:0]   rd;
   logic          er;

   pbec_top #(.TICK_CYCLES(TICKS)) i_dut (
      .mclk           (mclk),
      .rstn           (rstn),
      .soft_reset     (soft_reset),
      .apb_req        (apb_req),
      .prdata         (prdata),
      .pready         (pready),
      .pslverr        (pslverr),
      .lane           (lane),
      .tx_enable      (tx_enable),
      .rx_enable      (rx_enable),
      .pattern_select (pattern_select),
      .irq            (irq)
   );

   always #12.5 mclk = ~mclk;

   task results;
      $display("fail_count %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // one apb transfer; request held until pready is seen at a rising edge
   task apb(input logic w, input logic [15:0] idx, input logic [15:0] wd);
      int n;
      @(posedge mclk);
      apb_req.psel    <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite  <= w;
      apb_req.paddr   <= {idx, 2'b00};
      apb_req.pwdata  <= {16'h0000, wd};
      @(posedge mclk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready === 1'b1) begin
         rd = prdata[15:0];
         er = pslverr;
         apb_req.psel    <= 1'b0;
         apb_req.penable <= 1'b0;
      end else begin
         fail_count++;
         $display("CHECK FAILED apb_ready expected 1 seen 0");
         results();
      end
   endtask

   task wr(input logic [15:0] idx, input logic [15:0] wd);
      apb(1'b1, idx, wd);
   endtask

   task rchk(input logic [15:0] idx, input logic [15:0] ex, input string nm);
      apb(1'b0, idx, 16'h0000);
      `CHK(nm, ex, rd)
      `CHK("pslverr", 1'b0, er)
   endtask

   // m = {tx, rx, err}; each line high for n edges
   task burst(input logic [2:0] m, input int n);
      @(posedge mclk);
      lane.tx_bit <= m[2];
      lane.rx_bit <= m[1];
      lane.rx_err <= m[0];
      repeat (n) @(posedge mclk);
      lane.tx_bit <= 1'b0;
      lane.rx_bit <= 1'b0;
      lane.rx_err <= 1'b0;
   endtask

   task soft_pulse;
      @(posedge mclk);
      soft_reset <= 1'b1;
      @(posedge mclk);
      soft_reset <= 1'b0;
   endtask

   task irq_chk(input logic ex);
      repeat (3) @(negedge mclk);
      `CHK("irq", ex, irq)
   endtask

   initial begin
      mclk       = 1'b0;
      rstn       = 1'b0;
      soft_reset = 1'b0;
      apb_req    = '0;
      lane       = '0;
      fail_count = 0;
      compares   = 0;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      burst(3'b111, 5);
      for (int i = 0; i < 10; i++) begin
         rchk(PBEC_IDX_TX_LOW + 16'(i), 16'h0000, "count_word");
      end
      rchk(PBEC_IDX_CTRL, 16'h4000, "ctrl_reset");
      wr(PBEC_IDX_CTRL, 16'h4030);
      `CHK("tx_enable", 1'b1, tx_enable)
      `CHK("rx_enable", 1'b1, rx_enable)
      burst(3'b111, 65534);
      rchk(PBEC_IDX_TX_ALIAS, 16'hfffe, "tx_low");
      rchk(PBEC_IDX_RX_ALIAS, 16'hfffe, "rx_low");
      rchk(PBEC_IDX_ERR_ALIAS, 16'h0000, "err_unlocked");
      burst(3'b110, 5);
      rchk(PBEC_IDX_TX_MID, 16'h0000, "tx_mid_snap");
      rchk(PBEC_IDX_RX_MID, 16'h0000, "rx_mid_snap");
      rchk(PBEC_IDX_TX_LOW, 16'h0003, "tx_low2");
      rchk(PBEC_IDX_TX_LOW, 16'h0003, "tx_low_keep");
      rchk(PBEC_IDX_TX_MID, 16'h0001, "tx_mid");
      rchk(PBEC_IDX_TX_HIGH, 16'h0000, "tx_high");
      rchk(PBEC_IDX_RX_LOW, 16'h0003, "rx_low2");
      rchk(PBEC_IDX_RX_MID, 16'h0001, "rx_mid");
      rchk(PBEC_IDX_RX_HIGH, 16'h0000, "rx_high");
      // errors counted once locked, then before lock with immediate mode
      @(posedge mclk);
      lane.pattern_locked <= 1'b1;
      rchk(PBEC_IDX_CTRL, 16'h4130, "ctrl_locked");
      wr(PBEC_IDX_IRQ_MSK, 16'h0001);
      irq_chk(1'b0);
      burst(3'b001, 7);
      irq_chk(1'b1);
      apb(1'b0, PBEC_IDX_IRQ_STS, 16'h0000);
      `CHK("sts_err", 16'h0001, rd & 16'h0001)
      irq_chk(1'b0);
      @(posedge mclk);
      lane.pattern_locked <= 1'b0;
      wr(PBEC_IDX_CTRL, 16'h40b0);
      burst(3'b001, 3);
      rchk(PBEC_IDX_ERR_ALIAS, 16'h000a, "err_low");
      rchk(PBEC_IDX_ERR_MID, 16'h0000, "err_mid");
      // clear request with the timer held still
      wr(PBEC_IDX_CTRL, 16'h40e0);
      rchk(PBEC_IDX_CTRL, 16'h40a0, "ctrl_selfclr");
      rchk(PBEC_IDX_TX_LOW, 16'h0000, "tx_cleared");
      rchk(PBEC_IDX_ERR_ALIAS, 16'h0000, "err_cleared");
      rchk(PBEC_IDX_TIMER, 16'h0000, "tmr_cleared");
      // elapsed timer over a known 84-cycle window
      soft_pulse();
      rchk(PBEC_IDX_CTRL, 16'h4000, "ctrl_soft");
      wr(PBEC_IDX_CTRL, 16'h4010);
      repeat (80) @(posedge mclk);
      wr(PBEC_IDX_CTRL, 16'h4000);
      rchk(PBEC_IDX_TIMER, 16'h0000, "tmr_before");
      rchk(PBEC_IDX_ERR_LOW, 16'h0000, "err_low3");
      rchk(PBEC_IDX_TIMER, 16'(84 / TICKS), "tmr_ticks");
      wr(PBEC_IDX_IRQ_MSK, 16'h0002);
      irq_chk(1'b1);
      apb(1'b0, PBEC_IDX_IRQ_STS, 16'h0000);
      `CHK("sts_tick", 16'h0002, rd & 16'h0002)
      irq_chk(1'b0);
      wr(PBEC_IDX_CTRL, 16'h0010);
      repeat (40) @(posedge mclk);
      rchk(PBEC_IDX_ERR_LOW, 16'h0000, "err_low4");
      rchk(PBEC_IDX_TIMER, 16'(84 / TICKS), "tmr_legacy");
      // clear on read
      wr(PBEC_IDX_CTRL, 16'h6010);
      burst(3'b010, 4);
      rchk(PBEC_IDX_RX_LOW, 16'h0004, "rx_cor");
      rchk(PBEC_IDX_RX_LOW, 16'h0000, "rx_cor_zero");
      apb(1'b0, 16'h0000, 16'h0000);
      `CHK("unmapped_err", 1'b1, er)
      `CHK("unmapped_data", 16'h0000, rd)
      wr(PBEC_IDX_TX_LOW, 16'h1234);
      `CHK("ro_write_err", 1'b0, er)
      rchk(PBEC_IDX_TX_LOW, 16'h0000, "ro_write");
      // soft reset keeps clear-on-read, zeroes counts
      wr(PBEC_IDX_CTRL, 16'h6029);
      `CHK("pattern_select", 4'h9, pattern_select)
      burst(3'b100, 3);
      soft_pulse();
      rchk(PBEC_IDX_CTRL, 16'h6000, "ctrl_soft2");
      rchk(PBEC_IDX_TX_LOW, 16'h0000, "tx_soft");
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      rchk(PBEC_IDX_CTRL, 16'h4000, "ctrl_hard");
      results();
   end
endmodule // test_prbs_bit_error_counters
